// file: pwg_gate.sv
// What this block does
// - With unlock flag 0, processor writes to protected addresses are dropped.
// - With unlock flag 1, processor writes to protected addresses pass.
// - Reads from processor and debug port always pass, flag ignored.
// - Debug port writes always pass, whatever the flag.
// - Reset clears the unlock flag.
// - Unlock instruction sets the flag; processor issues it before writing.
// - Relock instruction clears the flag; processor issues it afterwards.
// - The flag lives as one bit of status word one.
// - Device configuration, protection start and range words are protected.
// - Flash option word and flash power, status, wait words are protected.
// - Eight security key words and security control word are protected.
// - Whole interrupt vector table 0x0D00 to 0x0DFF is protected.
// - Listed clocking, low-power and watchdog words are protected.
// - Six two-word port A pin control registers are protected.
// - Pull-up, misc configuration and port B pin registers are protected.
// - External interrupt and low-power pin select registers are protected.
// - CAN master control protects only bits 15-9 and 7-6.
`timescale 1ns/1ps
`default_nettype none
module pwg_gate
  import pwg_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic protected_write_unlock,
  input wire logic protected_write_relock_instr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [DATA_W-1:0] cpu_wdata,
  input wire logic [STRB_W-1:0] cpu_wstrb,
  output logic cpu_ready,
  output logic cpu_error,
  output logic [DATA_W-1:0] cpu_rdata,
  input wire logic dbg_wr,
  input wire logic dbg_rd,
  input wire logic [ADDR_W-1:0] dbg_addr,
  input wire logic [DATA_W-1:0] dbg_wdata,
  input wire logic [STRB_W-1:0] dbg_wstrb,
  output logic dbg_ready,
  output logic [DATA_W-1:0] dbg_rdata,
  output logic [15:0] cpu_status_word_one,
  output logic unlocked,
  output logic reg_wr,
  output logic reg_rd,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic [STRB_W-1:0] reg_wstrb,
  output logic [DATA_W-1:0] reg_wmask,
  input wire logic [DATA_W-1:0] reg_rdata
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic in_rng(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] lo,
                                  input logic [ADDR_W-1:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Whole-word protection; the CAN word is handled apart by a mask.
  function automatic logic is_prot(input logic [ADDR_W-1:0] a);
    logic p;
    p = 1'b0;
    p = p | in_rng(a, DEVCFG_LO, DEVCFG_HI);
    p = p | (a == PROT_START) | (a == PROT_RANGE);
    p = p | (a == FLASH_OPT) | in_rng(a, FLASH_LO, FLASH_HI);
    p = p | in_rng(a, KEY_LO, KEY_HI) | (a == SEC_CTRL);
    p = p | in_rng(a, VEC_LO, VEC_HI);
    p = p | (a == CLK_A) | (a == CLK_B) | in_rng(a, CLK_LO, CLK_HI);
    p = p | (a == CLK_C) | (a == CLK_D) | (a == CLK_E);
    p = p | (a == CLK_F) | (a == CLK_G);
    p = p | in_rng(a, PINA_LO, PINA_HI);
    p = p | in_rng(a, PINB_LO, PINB_HI);
    p = p | in_rng(a, XSEL_LO, XSEL_HI) | in_rng(a, LPSEL_LO, LPSEL_HI);
    is_prot = p;
  endfunction

  function automatic logic is_can_mc(input logic [ADDR_W-1:0] a);
    is_can_mc = (a == CAN_MC_A) || (a == CAN_MC_B);
  endfunction

  // ---------------------------------------------------------------
  // Unlock flag
  // ---------------------------------------------------------------
  logic [15:0] status_one;
  logic [15:0] next_status_one;

  always_comb begin
    next_status_one = status_one;
    // Relock wins if both arrive together, the safe side of the race.
    if (protected_write_relock_instr) begin
      next_status_one[UNLOCK_BIT] = 1'b0;
    end else if (protected_write_unlock) begin
      next_status_one[UNLOCK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status_one <= STATUS_ONE_RESET;
    end else begin
      status_one <= next_status_one;
    end
  end

  assign cpu_status_word_one = status_one;
  assign unlocked = status_one[UNLOCK_BIT];

  // ---------------------------------------------------------------
  // Access path
  // ---------------------------------------------------------------
  // The debug port has priority; the processor waits for as long as a debug access is active.
  logic dbg_act;
  logic cpu_prot;
  logic [DATA_W-1:0] cpu_mask;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] next_rdata_q;
  logic rd_src_dbg;
  logic next_rd_src_dbg;

  assign dbg_act = dbg_wr | dbg_rd;
  assign cpu_prot = is_prot(cpu_addr);

  always_comb begin
    cpu_mask = {DATA_W{1'b1}};
    if (!unlocked) begin
      if (cpu_prot) begin
        cpu_mask = '0;
      end else if (is_can_mc(cpu_addr)) begin
        cpu_mask = {{(DATA_W-16){1'b1}}, ~CAN_MC_MASK};
      end
    end
  end

  always_comb begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = cpu_addr;
    reg_wdata = cpu_wdata;
    reg_wstrb = cpu_wstrb;
    reg_wmask = cpu_mask;
    if (dbg_act) begin
      reg_wr = dbg_wr;
      reg_rd = dbg_rd;
      reg_addr = dbg_addr;
      reg_wdata = dbg_wdata;
      reg_wstrb = dbg_wstrb;
      reg_wmask = {DATA_W{1'b1}};
    end else begin
      reg_rd = cpu_rd;
      // A fully masked write is still dropped here, not just masked.
      reg_wr = cpu_wr && (cpu_mask != '0);
    end
  end

  assign dbg_ready = 1'b1;
  assign cpu_ready = !dbg_act;
  assign cpu_error = 1'b0;

  always_comb begin
    next_rdata_q = rdata_q;
    next_rd_src_dbg = rd_src_dbg;
    if (reg_rd) begin
      next_rdata_q = reg_rdata;
      next_rd_src_dbg = dbg_act;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= '0;
      rd_src_dbg <= 1'b0;
    end else begin
      rdata_q <= next_rdata_q;
      rd_src_dbg <= next_rd_src_dbg;
    end
  end

  // Read data is returned one cycle after the read strobe.
  assign cpu_rdata = rd_src_dbg ? '0 : rdata_q;
  assign dbg_rdata = rd_src_dbg ? rdata_q : '0;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_locked_drop: assert property (@(posedge clk) disable iff (srst)
    (!unlocked && !dbg_act && cpu_wr && cpu_prot) |-> !reg_wr)
    else $error("protected write passed while locked");

  chk_unlocked_pass: assert property (@(posedge clk) disable iff (srst)
    (unlocked && !dbg_act && cpu_wr) |-> (reg_wr && reg_wmask == '1))
    else $error("write blocked while unlocked");

  chk_read_pass: assert property (@(posedge clk) disable iff (srst)
    (cpu_rd || dbg_rd) |-> reg_rd)
    else $error("read blocked");

  chk_dbg_write: assert property (@(posedge clk) disable iff (srst)
    dbg_wr |-> (reg_wr && reg_wmask == '1 && reg_addr == dbg_addr))
    else $error("debug write blocked");

  chk_reset_lock: assert property (@(posedge clk)
    srst |=> !unlocked)
    else $error("flag not cleared by reset");

  chk_unlock_set: assert property (@(posedge clk) disable iff (srst)
    (protected_write_unlock && !protected_write_relock_instr) |=> unlocked)
    else $error("unlock did not set flag");

  chk_relock_clr: assert property (@(posedge clk) disable iff (srst)
    protected_write_relock_instr |=> !unlocked)
    else $error("relock did not clear flag");

  chk_flag_hold: assert property (@(posedge clk) disable iff (srst)
    (!protected_write_unlock && !protected_write_relock_instr)
      |=> $stable(cpu_status_word_one))
    else $error("status word changed without cause");

  chk_can_mask: assert property (@(posedge clk) disable iff (srst)
    (!unlocked && !dbg_act && cpu_wr && is_can_mc(cpu_addr))
      |-> (reg_wr && reg_wmask[15:0] == 16'h01_3F))
    else $error("CAN mask wrong");

  chk_free_write: assert property (@(posedge clk) disable iff (srst)
    (!dbg_act && cpu_wr && !cpu_prot && !is_can_mc(cpu_addr))
      |-> (reg_wr && reg_wmask == '1))
    else $error("unprotected write altered");

  chk_no_fault: assert property (@(posedge clk) disable iff (srst)
    (cpu_wr && !dbg_act) |-> (cpu_ready && !cpu_error))
    else $error("blocked write faulted");

  cov_locked_drop: cover property (@(posedge clk) disable iff (srst)
    !unlocked && cpu_wr && cpu_prot && !dbg_act);
  cov_unlock_write: cover property (@(posedge clk) disable iff (srst)
    protected_write_unlock ##1 (cpu_wr && cpu_prot) ##1
    protected_write_relock_instr);
  cov_dbg_locked: cover property (@(posedge clk) disable iff (srst)
    !unlocked && dbg_wr && is_prot(dbg_addr));

endmodule
`default_nettype wire

// file: pwg_pkg.sv
package pwg_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int STRB_W = 2;

  // ---------------------------------------------------------------
  // Status word one
  // ---------------------------------------------------------------
  localparam int UNLOCK_BIT = 6;
  localparam logic [15:0] STATUS_ONE_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Protected word addresses
  // ---------------------------------------------------------------
  localparam logic [21:0] DEVCFG_LO = 22'h00_0880;
  localparam logic [21:0] DEVCFG_HI = 22'h00_0881;
  localparam logic [21:0] PROT_START = 22'h00_0884;
  localparam logic [21:0] PROT_RANGE = 22'h00_0885;
  localparam logic [21:0] FLASH_OPT = 22'h00_0A80;
  localparam logic [21:0] FLASH_LO = 22'h00_0A82;
  localparam logic [21:0] FLASH_HI = 22'h00_0A87;
  localparam logic [21:0] KEY_LO = 22'h00_0AE0;
  localparam logic [21:0] KEY_HI = 22'h00_0AE7;
  localparam logic [21:0] SEC_CTRL = 22'h00_0AEF;
  localparam logic [21:0] VEC_LO = 22'h00_0D00;
  localparam logic [21:0] VEC_HI = 22'h00_0DFF;
  localparam logic [21:0] PINA_LO = 22'h00_6F80;
  localparam logic [21:0] PINA_HI = 22'h00_6F8B;
  localparam logic [21:0] PINB_LO = 22'h00_6F8C;
  localparam logic [21:0] PINB_HI = 22'h00_6F9D;
  localparam logic [21:0] XSEL_LO = 22'h00_6FE0;
  localparam logic [21:0] XSEL_HI = 22'h00_6FE2;
  localparam logic [21:0] LPSEL_LO = 22'h00_6FE8;
  localparam logic [21:0] LPSEL_HI = 22'h00_6FE9;
  localparam logic [21:0] CLK_A = 22'h00_7010;
  localparam logic [21:0] CLK_B = 22'h00_7011;
  localparam logic [21:0] CLK_LO = 22'h00_7019;
  localparam logic [21:0] CLK_HI = 22'h00_701E;
  localparam logic [21:0] CLK_C = 22'h00_7021;
  localparam logic [21:0] CLK_D = 22'h00_7022;
  localparam logic [21:0] CLK_E = 22'h00_7023;
  localparam logic [21:0] CLK_F = 22'h00_7025;
  localparam logic [21:0] CLK_G = 22'h00_7029;
  localparam logic [21:0] CAN_MC_A = 22'h00_6014;
  localparam logic [21:0] CAN_MC_B = 22'h00_6214;

  // Protected bits of the CAN master control low word.
  localparam logic [15:0] CAN_MC_MASK = 16'hFE_C0;

endpackage

// file: pwg_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwg_regfile_model
  import pwg_pkg::*;
(
  input wire logic clk,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_wmask,
  output logic [DATA_W-1:0] reg_rdata
);
  // ----------------------------------------------------------
  // Flat register store, 65536 words indexed by the low 16 address bits
  // ----------------------------------------------------------
  logic [DATA_W-1:0] mem [65536];
  logic [DATA_W-1:0] last = '0;

  initial begin
    foreach (mem[i]) begin
      mem[i] = '0;
    end
  end

  // Masked bits keep their old value, as a real register would.
  always @(posedge clk) begin
    if (reg_wr) begin
      mem[reg_addr[15:0]] <= (mem[reg_addr[15:0]] & ~reg_wmask)
                             | (reg_wdata & reg_wmask);
    end
    if (reg_rd) begin
      last <= reg_rdata;
    end
  end

  // An idle read bus shows the inverse of the last word, not a stale copy.
  always_comb begin
    reg_rdata = reg_rd ? mem[reg_addr[15:0]] : ~last;
  end
endmodule
`default_nettype wire

// file: tb_protected_register_write_gate.sv
`timescale 1ns/1ps
`default_nettype none
module tb_protected_register_write_gate
  import pwg_pkg::*;
;
  logic clk = 0, srst = 1, unl = 0, rel = 0;
  logic cwr = 0, crd = 0, dwr = 0, drd = 0;
  logic [ADDR_W-1:0] ca = '0, da = '0, ra;
  logic [DATA_W-1:0] cwd = '0, dwd = '0, crdata, drdata, wmask, rrd, rwd;
  logic [15:0] st1;
  logic cready, cerr, unlocked, rwr, rrdn, s_wr, s_rdy, s_err, dready;
  logic [DATA_W-1:0] s_mask, s_rdata;
  int n_errors = 0, num_checks = 0;
  logic [15:0] prot [28] = '{16'h0880, 16'h0881, 16'h0884, 16'h0885,
    16'h0A80, 16'h0A82, 16'h0A87, 16'h0AE0, 16'h0AE7, 16'h0AEF, 16'h0D00,
    16'h0DFF, 16'h6F80, 16'h6F8B, 16'h6F8C, 16'h6F9D, 16'h6FE0, 16'h6FE2,
    16'h6FE8, 16'h7010, 16'h7011, 16'h7019, 16'h701E, 16'h7021, 16'h7022,
    16'h7023, 16'h7025, 16'h7029};
  logic [15:0] free [14] = '{16'h0882, 16'h0883, 16'h0886, 16'h0A81,
    16'h0A88, 16'h0AE8, 16'h0CFF, 16'h0E00, 16'h6F7F, 16'h6FC0, 16'h7012,
    16'h7018, 16'h7024, 16'h702A};

  pwg_gate DUT (.clk(clk), .srst(srst), .protected_write_unlock(unl),
    .protected_write_relock_instr(rel), .cpu_wr(cwr), .cpu_rd(crd),
    .cpu_addr(ca), .cpu_wdata(cwd), .cpu_wstrb(2'h3), .cpu_ready(cready),
    .cpu_error(cerr), .cpu_rdata(crdata), .dbg_wr(dwr), .dbg_rd(drd),
    .dbg_addr(da), .dbg_wdata(dwd), .dbg_wstrb(2'h3), .dbg_ready(dready),
    .dbg_rdata(drdata), .cpu_status_word_one(st1), .unlocked(unlocked),
    .reg_wr(rwr), .reg_rd(rrdn), .reg_addr(ra), .reg_wdata(rwd),
    .reg_wstrb(), .reg_wmask(wmask), .reg_rdata(rrd));
  pwg_regfile_model regs (.clk(clk), .reg_wr(rwr), .reg_rd(rrdn),
    .reg_addr(ra), .reg_wdata(rwd), .reg_wmask(wmask), .reg_rdata(rrd));

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask

  // One access held for one cycle; combinational answers sampled mid-cycle.
  task automatic acc(input bit d, input bit w, input logic [15:0] a,
                     input logic [DATA_W-1:0] v);
    @(posedge clk);
    if (d) begin
      dwr <= w;
      drd <= !w;
      da <= {6'h00, a};
      dwd <= v;
    end else begin
      cwr <= w;
      crd <= !w;
      ca <= {6'h00, a};
      cwd <= v;
    end
    @(negedge clk);
    s_wr = rwr;
    s_rdy = cready;
    s_err = cerr;
    s_mask = wmask;
    @(posedge clk);
    {cwr, crd, dwr, drd} <= 4'h0;
    #1;
    s_rdata = d ? drdata : crdata;
  endtask

  task automatic instr(input logic u, input logic r);
    @(posedge clk);
    unl <= u;
    rel <= r;
    @(posedge clk);
    unl <= 0;
    rel <= 0;
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_locked();
    logic [DATA_W-1:0] v;
    chk(unlocked === 1'b0 && st1 === 16'h0000, "flag after reset");
    foreach (prot[i]) begin
      v = {prot[i], 16'hA5C3};
      acc(1, 1, prot[i], v);
      chk(s_wr === 1'b1, "debug write");
      acc(0, 1, prot[i], ~v);
      chk(s_wr === 0 && s_rdy === 1 && s_err === 0, "locked");
      acc(0, 0, prot[i], '0);
      chk(s_rdata === v, "cpu read");
      acc(1, 0, prot[i], '0);
      chk(s_rdata === v, "debug read");
    end
    foreach (free[i]) begin
      acc(0, 1, free[i], 32'h1234_5678);
      chk(s_wr === 1'b1 && s_rdy === 1'b1, "free write");
    end
  endtask

  task automatic t_unlock();
    instr(1, 0);
    chk(unlocked === 1'b1 && st1 === 16'h0040, "unlock");
    foreach (prot[i]) begin
      acc(0, 1, prot[i], {16'h0F0F, prot[i]});
      chk(s_wr === 1'b1 && s_mask === '1, "open write");
      acc(0, 0, prot[i], '0);
      chk(s_rdata === {16'h0F0F, prot[i]}, "open readback");
    end
    instr(0, 1);
    chk(unlocked === 1'b0 && st1 === 16'h0000, "relock");
    acc(0, 1, 16'h7029, '0);
    chk(s_wr === 1'b0 && s_rdy === 1'b1, "write after relock");
    instr(1, 0);
    instr(1, 1);
    chk(unlocked === 1'b0, "relock beats unlock");
  endtask

  // Only some bits of the CAN master control word are guarded.
  task automatic t_can();
    logic [15:0] a [2] = '{16'h6014, 16'h6214};
    foreach (a[i]) begin
      acc(1, 1, a[i], '0);
      acc(0, 1, a[i], 32'h0000_FFFF);
      chk(s_wr === 1'b1 && s_mask[15:0] === 16'h013F, "can mask");
      acc(0, 0, a[i], '0);
      chk(s_rdata[15:0] === 16'h013F, "can readback");
    end
  endtask

  // Both ports in one cycle: the debug port takes it, the processor waits.
  task automatic t_contend();
    @(posedge clk);
    cwr <= 1;
    ca <= 22'h00_7029;
    dwr <= 1;
    da <= 22'h00_0AE0;
    @(negedge clk);
    chk(cready === 0 && rwr === 1 && ra === 22'h00_0AE0, "dbg first");
    chk(dready === 1'b1 && cerr === 1'b0, "dbg ready");
    @(posedge clk);
    cwr <= 0;
    dwr <= 0;
  endtask

  // A reset in mid-run must lock again.
  task automatic t_reset();
    instr(1, 0);
    chk(unlocked === 1'b1, "unlock before reset");
    @(posedge clk);
    srst <= 1;
    @(posedge clk);
    srst <= 0;
    #1;
    chk(unlocked === 1'b0 && st1 === 16'h0000, "mid-run reset");
  endtask

  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 4000);
    n_errors++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    #1;
    t_locked();
    t_unlock();
    t_can();
    t_contend();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
